// ==== sfpe_pkg.sv ====
// shared constants and types of the serial flash program, erase and sleep sequencer
package sfpe_pkg;

  // ----------------------------------------------------------------
  // clock and framing
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_MHZ      = 125;
  localparam logic [5:0]  OPCODE_EDGES     = 6'h08;
  localparam logic [5:0]  NARROW_HDR_EDGES = 6'h20; // opcode plus three address bytes
  localparam logic [5:0]  WIDE_HDR_EDGES   = 6'h28; // opcode plus four address bytes
  localparam int unsigned PAGE_BYTES       = 256;
  localparam int unsigned PAGE_LOG2        = 8;
  localparam int unsigned FULL_BLOCK_LOG2  = 16;
  localparam int unsigned BLOCKS_LOG2      = 10;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE     = 8'h04;
  localparam logic [7:0] OP_QUAD_PROGRAM      = 8'h32;
  localparam logic [7:0] OP_QUAD_PROGRAM_WIDE = 8'h34;
  localparam logic [7:0] OP_SECTOR_ERASE      = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_WIDE = 8'h21;
  localparam logic [7:0] OP_HALF_BLOCK        = 8'h52;
  localparam logic [7:0] OP_HALF_BLOCK_WIDE   = 8'h5C;
  localparam logic [7:0] OP_FULL_BLOCK        = 8'hD8;
  localparam logic [7:0] OP_FULL_BLOCK_WIDE   = 8'hDC;
  localparam logic [7:0] OP_CHIP_ERASE_A      = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B      = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP        = 8'hB9;
  localparam logic [7:0] OP_RELEASE           = 8'hAB;
  localparam logic [7:0] OP_ENTER_WIDE        = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE         = 8'hE9;
  localparam logic [7:0] OP_SOFT_RESET        = 8'hF0; // arbitrary value

  // ----------------------------------------------------------------
  // erase spans and default cycle times in ns
  // ----------------------------------------------------------------
  localparam logic [31:0] SECTOR_SPAN_MASK = 32'h0000_0FFF;
  localparam logic [31:0] HALF_SPAN_MASK   = 32'h0000_7FFF;
  localparam logic [31:0] FULL_SPAN_MASK   = 32'h0000_FFFF;
  localparam int unsigned PROGRAM_CYCLE_TIME_NS = 400000;
  localparam int unsigned SECTOR_ERASE_TIME_NS  = 50000000;
  localparam int unsigned BLOCK_ERASE_TIME_NS   = 200000000;
  localparam int unsigned ARRAY_ERASE_TIME_NS   = 1000000000;
  localparam int unsigned SLEEP_ENTRY_DELAY_NS  = 3000;

  typedef enum logic [2:0] {
    SFPE_IDLE       = 3'b000,
    SFPE_PROGRAM    = 3'b001,
    SFPE_ERASE      = 3'b010,
    SFPE_SLEEP_WAIT = 3'b011,
    SFPE_SLEEP      = 3'b100
  } sfpe_state_t;

  typedef enum logic [1:0] {
    SFPE_ERASE_SECTOR = 2'b00,
    SFPE_ERASE_HALF   = 2'b01,
    SFPE_ERASE_FULL   = 2'b10,
    SFPE_ERASE_CHIP   = 2'b11
  } sfpe_erase_kind_t;

endpackage

// ==== sfpe_sequencer.sv ====
// program, erase and deep sleep command sequencer of a serial nor flash
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1: quad program opcodes 32H (mode-sized address) and 34H (four-byte address), quad data
// RQ2: program and erase run only when the write enable latch was set before
// RQ3: over 256 data bytes, only the last 256 received are programmed in the page
// RQ4: fewer bytes program only their own locations, other page bytes untouched
// RQ5: program runs only if chip select rises on a data byte boundary
// RQ6: program cycle starts at chip select rise, in progress reads 1 until done
// RQ7: write enable latch is cleared before each program or erase cycle ends
// RQ8: program aimed at a protected page is not executed
// RQ9: sector erase opcodes 20H and four-byte 21H, address on serial input
// RQ10: half block erase opcodes 52H and four-byte 5CH
// RQ11: full block erase opcodes D8H and four-byte DCH
// RQ12: erase takes any address in the region and erases the whole region
// RQ13: erase runs only if chip select rises right after the last address bit
// RQ14: host holds chip select low for the whole command sequence
// RQ15: erase cycles start at chip select rise, in progress reads 1 until done
// RQ16: erase of a protected region is refused, array untouched
// RQ17: chip erase opcodes 60H or C7H, opcode only, whole array
// RQ18: chip erase ignored while any block is protected
// RQ19: opcode-only commands need chip select rise right after the eighth bit
// RQ20: deep sleep opcode B9H, sleep entered after the entry delay elapses
// RQ21: while asleep only release and software reset commands are obeyed; the code also obeys write disable 04H there and clears the latch
// RQ22: deep sleep request during a busy cycle is rejected, cycle undisturbed
// RQ23: address size flag picks three or four byte addresses, B7H sets, E9H clears
// RQ24: quad data carries four bits per edge, high nibble of each byte first
// RQ25: refused commands leave write enable latch and in progress unchanged
module sfpe_sequencer #(
  parameter int unsigned PROGRAM_CYCLE_TIME_NS = sfpe_pkg::PROGRAM_CYCLE_TIME_NS,
  parameter int unsigned SECTOR_ERASE_TIME_NS  = sfpe_pkg::SECTOR_ERASE_TIME_NS,
  parameter int unsigned BLOCK_ERASE_TIME_NS   = sfpe_pkg::BLOCK_ERASE_TIME_NS,
  parameter int unsigned ARRAY_ERASE_TIME_NS   = sfpe_pkg::ARRAY_ERASE_TIME_NS,
  parameter int unsigned SLEEP_ENTRY_DELAY_NS  = sfpe_pkg::SLEEP_ENTRY_DELAY_NS,
  parameter int unsigned BLOCKS_LOG2           = sfpe_pkg::BLOCKS_LOG2
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_sclk,
  input  wire logic                          i_cs_n,
  input  wire logic                          i_quad_line_0,
  input  wire logic                          i_quad_line_1,
  input  wire logic                          i_quad_line_2,
  input  wire logic                          i_quad_line_3,
  input  wire logic                          i_protect_level_bit3,
  input  wire logic                          i_protect_level_bit2,
  input  wire logic                          i_protect_level_bit1,
  input  wire logic                          i_protect_level_bit0,
  input  wire logic                          i_protect_top_bottom_select,
  output logic                               o_write_enable_latch,
  output logic                               o_write_in_progress,
  output logic                               o_address_size_flag,
  output logic                               o_deep_sleep,
  output logic                               o_pgm_we,
  output logic [31:0]                        o_pgm_addr,
  output logic [7:0]                         o_pgm_data,
  output logic                               o_erase_start,
  output logic [31:0]                        o_erase_addr,
  output sfpe_pkg::sfpe_erase_kind_t         o_erase_kind
);

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam logic [31:0] PROGRAM_CYCLES =
    32'((64'(PROGRAM_CYCLE_TIME_NS) * 64'(sfpe_pkg::REF_CLK_MHZ) + 64'd999) / 64'd1000);
  localparam logic [31:0] SECTOR_CYCLES =
    32'((64'(SECTOR_ERASE_TIME_NS) * 64'(sfpe_pkg::REF_CLK_MHZ) + 64'd999) / 64'd1000);
  localparam logic [31:0] BLOCK_CYCLES =
    32'((64'(BLOCK_ERASE_TIME_NS) * 64'(sfpe_pkg::REF_CLK_MHZ) + 64'd999) / 64'd1000);
  localparam logic [31:0] ARRAY_CYCLES =
    32'((64'(ARRAY_ERASE_TIME_NS) * 64'(sfpe_pkg::REF_CLK_MHZ) + 64'd999) / 64'd1000);
  localparam logic [31:0] SLEEP_CYCLES =
    32'((64'(SLEEP_ENTRY_DELAY_NS) * 64'(sfpe_pkg::REF_CLK_MHZ) + 64'd999) / 64'd1000);
  localparam int unsigned PB = sfpe_pkg::PAGE_BYTES;

  // refuse settings the page walk or the block decode cannot serve
  if (PROGRAM_CYCLES <= 32'(PB) || SECTOR_CYCLES == 32'h0 || BLOCK_CYCLES == 32'h0 ||
      ARRAY_CYCLES == 32'h0 || SLEEP_CYCLES == 32'h0) begin : g_bad_time
    $error("cycle time too short");
  end
  if (BLOCKS_LOG2 < 1 || BLOCKS_LOG2 > 16) begin : g_bad_blocks
    $error("block count out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_prog_op(input logic [7:0] op);
    return op == sfpe_pkg::OP_QUAD_PROGRAM || op == sfpe_pkg::OP_QUAD_PROGRAM_WIDE;
  endfunction

  function automatic logic is_wide_op(input logic [7:0] op);
    return op == sfpe_pkg::OP_QUAD_PROGRAM_WIDE || op == sfpe_pkg::OP_SECTOR_ERASE_WIDE ||
           op == sfpe_pkg::OP_HALF_BLOCK_WIDE || op == sfpe_pkg::OP_FULL_BLOCK_WIDE;
  endfunction

  // block protect: level n covers 2^(n-1) blocks at the top or the bottom
  function automatic logic block_protected(input logic [31:0] a, input logic [3:0] lvl,
                                           input logic tb);
    logic [BLOCKS_LOG2-1:0] blk;
    logic [BLOCKS_LOG2-1:0] ones;
    int unsigned            k;
    blk  = a[sfpe_pkg::FULL_BLOCK_LOG2 +: BLOCKS_LOG2];
    ones = '1;
    k    = 32'(lvl) - 1;
    if (lvl == 4'h0) begin
      return 1'b0;
    end
    if (k >= BLOCKS_LOG2) begin
      return 1'b1;
    end
    if (tb) begin
      return (blk >> k) == '0;
    end
    return (blk >> k) == (ones >> k);
  endfunction

  // ----------------------------------------------------------------
  // link side: serial clock domain
  // ----------------------------------------------------------------
  logic              rst_link_reg;
  logic [5:0]        edge_cnt_reg;
  logic              nib_hi_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        op_reg;
  logic              wide_reg;
  logic [31:0]       addr_reg;
  logic [7:0]        col_reg;
  logic [3:0]        hi_nib_reg;
  logic              frame_tog_reg;
  logic              op_only_reg;
  logic              addr_exact_reg;
  logic              data_aligned_reg;
  logic              ads_l1_reg;
  logic              ads_l2_reg;
  logic              busy_l1_reg;
  logic              busy_l2_reg;
  logic              busy_reg;
  logic [PB-1:0]     mask_reg;
  logic [7:0]        page_reg [PB];
  logic [7:0]        op_next;
  logic [3:0]        quad_nib;
  logic [5:0]        hdr_len;
  logic              in_data;
  logic              addr_phase;
  logic              addr_last;
  logic              byte_done;

  assign op_next    = {shift_reg[6:0], i_quad_line_0};
  assign quad_nib   = {i_quad_line_3, i_quad_line_2, i_quad_line_1, i_quad_line_0}; // RQ24
  assign hdr_len    = wide_reg ? sfpe_pkg::WIDE_HDR_EDGES : sfpe_pkg::NARROW_HDR_EDGES;
  assign in_data    = edge_cnt_reg >= sfpe_pkg::OPCODE_EDGES && edge_cnt_reg == hdr_len;
  assign addr_phase = edge_cnt_reg >= sfpe_pkg::OPCODE_EDGES && !in_data;
  assign addr_last  = addr_phase && edge_cnt_reg == hdr_len - 6'h01;
  // second nibble of a data byte of an accepted-looking program frame
  assign byte_done  = in_data && !nib_hi_reg && is_prog_op(op_reg) && !busy_l2_reg;

  // reset copy for the link domain, released while the serial clock stands still
  always_ff @(posedge i_ref_clk) begin
    rst_link_reg <= i_reset;
  end

  // frame position, cleared whenever chip select is high
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      edge_cnt_reg <= 6'h00;
      nib_hi_reg   <= 1'b1;
    end else if (!in_data) begin
      edge_cnt_reg <= edge_cnt_reg + 6'h01;
    end else begin
      nib_hi_reg <= ~nib_hi_reg;
    end
  end

  // opcode, address and frame-end summary, held after chip select rises
  always_ff @(posedge i_sclk or posedge rst_link_reg) begin
    if (rst_link_reg) begin
      shift_reg        <= 8'h00;
      op_reg           <= 8'h00;
      wide_reg         <= 1'b0;
      addr_reg         <= 32'h0000_0000;
      col_reg          <= 8'h00;
      frame_tog_reg    <= 1'b0;
      op_only_reg      <= 1'b0;
      addr_exact_reg   <= 1'b0;
      data_aligned_reg <= 1'b0;
    end else begin
      shift_reg <= op_next;
      if (edge_cnt_reg == 6'h00) begin
        frame_tog_reg <= ~frame_tog_reg; // first edge of a frame
      end
      if (edge_cnt_reg == sfpe_pkg::OPCODE_EDGES - 6'h01) begin
        op_reg   <= op_next;
        wide_reg <= ads_l2_reg | is_wide_op(op_next); // RQ1 RQ23
        addr_reg <= 32'h0000_0000;
      end
      if (addr_phase) begin
        addr_reg <= {addr_reg[30:0], i_quad_line_0}; // RQ9 RQ10 RQ11
      end
      if (addr_last) begin
        col_reg <= {addr_reg[6:0], i_quad_line_0};
      end else if (byte_done) begin
        col_reg <= col_reg + 8'h01; // wraps inside the page
      end
      op_only_reg      <= edge_cnt_reg == sfpe_pkg::OPCODE_EDGES - 6'h01; // RQ19
      addr_exact_reg   <= addr_last; // RQ13
      data_aligned_reg <= in_data && !nib_hi_reg; // RQ5
    end
  end

  // address size and busy levels into the link domain
  always_ff @(posedge i_sclk or posedge rst_link_reg) begin
    if (rst_link_reg) begin
      ads_l1_reg  <= 1'b0;
      ads_l2_reg  <= 1'b0;
      busy_l1_reg <= 1'b0;
      busy_l2_reg <= 1'b0;
    end else begin
      ads_l1_reg  <= o_address_size_flag;
      ads_l2_reg  <= ads_l1_reg;
      busy_l1_reg <= busy_reg;
      busy_l2_reg <= busy_l1_reg;
    end
  end

  // first data nibble of a byte
  always_ff @(posedge i_sclk) begin
    if (in_data && nib_hi_reg) begin
      hi_nib_reg <= quad_nib; // RQ24
    end
  end

  // page buffer: later bytes overwrite earlier ones at the same column
  for (genvar e = 0; e < PB; e++) begin : g_page
    always_ff @(posedge i_sclk or posedge rst_link_reg) begin
      if (rst_link_reg) begin
        mask_reg[e] <= 1'b0;
      end else if (addr_last && is_prog_op(op_reg) && !busy_l2_reg) begin
        mask_reg[e] <= 1'b0; // RQ4
      end else if (byte_done && col_reg == 8'(e)) begin
        mask_reg[e] <= 1'b1; // RQ3
      end
    end
    always_ff @(posedge i_sclk) begin
      if (byte_done && col_reg == 8'(e)) begin
        page_reg[e] <= {hi_nib_reg, quad_nib}; // RQ3
      end
    end
  end

  // ----------------------------------------------------------------
  // core side: reference clock domain
  // ----------------------------------------------------------------
  sfpe_pkg::sfpe_state_t state_reg;
  logic                  cs_s1_reg;
  logic                  cs_s2_reg;
  logic                  cs_s3_reg;
  logic                  tog_s1_reg;
  logic                  tog_s2_reg;
  logic                  seen_reg;
  logic [31:0]           timer_reg;
  logic [8:0]            idx_reg;
  logic [23:0]           pgm_page_reg;
  logic [3:0]            prot_lvl;
  logic                  frame_end;
  logic                  ready;
  logic                  asleep;
  logic                  go_prog;
  logic                  go_erase;
  logic                  go_sleep;
  logic                  go_wake;
  sfpe_pkg::sfpe_erase_kind_t erase_kind;
  logic [31:0]           erase_mask;
  logic [31:0]           erase_cycles;
  logic                  erase_op;

  assign prot_lvl = {i_protect_level_bit3, i_protect_level_bit2,
                     i_protect_level_bit1, i_protect_level_bit0};
  // summary words are stable here: the serial clock stops before chip select rises
  assign frame_end = cs_s2_reg && !cs_s3_reg && (tog_s2_reg != seen_reg);
  assign ready     = state_reg == sfpe_pkg::SFPE_IDLE;
  assign asleep    = state_reg == sfpe_pkg::SFPE_SLEEP;

  // chip select and frame toggle synchronisers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      seen_reg   <= 1'b0;
    end else begin
      cs_s1_reg  <= i_cs_n;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      tog_s1_reg <= frame_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      if (cs_s2_reg && !cs_s3_reg) begin
        seen_reg <= tog_s2_reg;
      end
    end
  end

  // erase opcode decode: kind, region span and cycle length
  always_comb begin
    erase_op     = 1'b1;
    erase_kind   = sfpe_pkg::SFPE_ERASE_SECTOR;
    erase_mask   = sfpe_pkg::SECTOR_SPAN_MASK;
    erase_cycles = SECTOR_CYCLES;
    unique case (op_reg)
      sfpe_pkg::OP_SECTOR_ERASE, sfpe_pkg::OP_SECTOR_ERASE_WIDE: begin // RQ9
        erase_kind = sfpe_pkg::SFPE_ERASE_SECTOR;
      end
      sfpe_pkg::OP_HALF_BLOCK, sfpe_pkg::OP_HALF_BLOCK_WIDE: begin // RQ10
        erase_kind   = sfpe_pkg::SFPE_ERASE_HALF;
        erase_mask   = sfpe_pkg::HALF_SPAN_MASK;
        erase_cycles = BLOCK_CYCLES;
      end
      sfpe_pkg::OP_FULL_BLOCK, sfpe_pkg::OP_FULL_BLOCK_WIDE: begin // RQ11
        erase_kind   = sfpe_pkg::SFPE_ERASE_FULL;
        erase_mask   = sfpe_pkg::FULL_SPAN_MASK;
        erase_cycles = BLOCK_CYCLES;
      end
      sfpe_pkg::OP_CHIP_ERASE_A, sfpe_pkg::OP_CHIP_ERASE_B: begin // RQ17
        erase_kind   = sfpe_pkg::SFPE_ERASE_CHIP;
        erase_mask   = 32'hFFFF_FFFF;
        erase_cycles = ARRAY_CYCLES;
      end
      default: begin
        erase_op = 1'b0;
      end
    endcase
  end

  // acceptance of a finished frame; anything refused changes nothing
  always_comb begin
    go_prog  = frame_end && ready && o_write_enable_latch && is_prog_op(op_reg) &&
               data_aligned_reg && // RQ2 RQ5
               !block_protected(addr_reg, prot_lvl, i_protect_top_bottom_select); // RQ8
    go_erase = 1'b0;
    if (frame_end && ready && o_write_enable_latch && erase_op) begin // RQ2 RQ25
      if (erase_kind == sfpe_pkg::SFPE_ERASE_CHIP) begin
        go_erase = op_only_reg && prot_lvl == 4'h0; // RQ18 RQ19
      end else begin
        go_erase = addr_exact_reg && // RQ13
                   !block_protected(addr_reg, prot_lvl, i_protect_top_bottom_select); // RQ16
      end
    end
    go_sleep = frame_end && ready && op_only_reg && op_reg == sfpe_pkg::OP_DEEP_SLEEP; // RQ22
    go_wake  = frame_end && asleep && op_only_reg && // RQ21
               (op_reg == sfpe_pkg::OP_RELEASE || op_reg == sfpe_pkg::OP_SOFT_RESET);
  end

  // sequencer state and cycle timer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= sfpe_pkg::SFPE_IDLE;
      timer_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        sfpe_pkg::SFPE_IDLE: begin
          if (go_prog) begin
            state_reg <= sfpe_pkg::SFPE_PROGRAM; // RQ6
            timer_reg <= PROGRAM_CYCLES - 32'h1;
          end else if (go_erase) begin
            state_reg <= sfpe_pkg::SFPE_ERASE; // RQ15
            timer_reg <= erase_cycles - 32'h1;
          end else if (go_sleep) begin
            state_reg <= sfpe_pkg::SFPE_SLEEP_WAIT; // RQ20
            timer_reg <= SLEEP_CYCLES - 32'h1;
          end
        end
        sfpe_pkg::SFPE_PROGRAM, sfpe_pkg::SFPE_ERASE: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg <= sfpe_pkg::SFPE_IDLE; // RQ6 RQ15
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        sfpe_pkg::SFPE_SLEEP_WAIT: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg <= sfpe_pkg::SFPE_SLEEP; // RQ20
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        sfpe_pkg::SFPE_SLEEP: begin
          if (go_wake) begin
            state_reg <= sfpe_pkg::SFPE_IDLE; // RQ21
          end
        end
        default: begin
          state_reg <= sfpe_pkg::SFPE_IDLE;
        end
      endcase
    end
  end

  // write enable latch: cleared as each cycle starts
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_write_enable_latch <= 1'b0;
    end else if (go_prog || go_erase) begin
      o_write_enable_latch <= 1'b0; // RQ7
    end else if (frame_end && op_only_reg && (ready || asleep) &&
                 (op_reg == sfpe_pkg::OP_WRITE_DISABLE ||
                  (asleep && op_reg == sfpe_pkg::OP_SOFT_RESET))) begin
      o_write_enable_latch <= 1'b0;
    end else if (frame_end && op_only_reg && ready &&
                 op_reg == sfpe_pkg::OP_WRITE_ENABLE) begin
      o_write_enable_latch <= 1'b1; // RQ2
    end
  end

  // address size flag
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_address_size_flag <= 1'b0;
    end else if (frame_end && op_only_reg && ready) begin
      if (op_reg == sfpe_pkg::OP_ENTER_WIDE) begin
        o_address_size_flag <= 1'b1; // RQ23
      end else if (op_reg == sfpe_pkg::OP_EXIT_WIDE) begin
        o_address_size_flag <= 1'b0; // RQ23
      end
    end
  end

  // busy level for the link side and the page walk during a program cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_reg     <= 1'b0;
      idx_reg      <= 9'h000;
      pgm_page_reg <= 24'h00_0000;
      o_pgm_we     <= 1'b0;
      o_pgm_addr   <= 32'h0000_0000;
      o_pgm_data   <= 8'h00;
    end else begin
      busy_reg <= !ready;
      o_pgm_we <= 1'b0;
      if (go_prog) begin
        idx_reg      <= 9'h000;
        pgm_page_reg <= addr_reg[31:8];
      end else if (state_reg == sfpe_pkg::SFPE_PROGRAM && idx_reg < 9'(PB)) begin
        idx_reg    <= idx_reg + 9'h001;
        o_pgm_we   <= mask_reg[idx_reg[7:0]]; // RQ3 RQ4
        o_pgm_addr <= {pgm_page_reg, idx_reg[7:0]};
        o_pgm_data <= page_reg[idx_reg[7:0]];
      end
    end
  end

  // erase request to the array, region aligned down
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_erase_start <= 1'b0;
      o_erase_addr  <= 32'h0000_0000;
      o_erase_kind  <= sfpe_pkg::SFPE_ERASE_SECTOR;
    end else begin
      o_erase_start <= go_erase;
      if (go_erase) begin
        o_erase_addr <= addr_reg & ~erase_mask; // RQ12
        o_erase_kind <= erase_kind;
      end
    end
  end

  assign o_write_in_progress = state_reg == sfpe_pkg::SFPE_PROGRAM ||
                               state_reg == sfpe_pkg::SFPE_ERASE; // RQ6 RQ15
  assign o_deep_sleep        = asleep; // RQ20

endmodule

`default_nettype wire

// ==== sfpe_sequencer_monitor.sv ====
// port checks of the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module sfpe_sequencer_monitor (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic o_write_enable_latch,
  input wire logic o_write_in_progress,
  input wire logic o_deep_sleep,
  input wire logic o_pgm_we,
  input wire logic o_erase_start,
  input wire logic [31:0] o_erase_addr,
  input wire sfpe_pkg::sfpe_erase_kind_t o_erase_kind
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // a cycle starts from a set latch and clears it at once
  sequence s_cycle_start;
    $rose(o_write_in_progress) ##0 ($past(o_write_enable_latch) && !o_write_enable_latch);
  endsequence
  a_cycle_needs_wel: assert property ($rose(o_write_in_progress) |-> s_cycle_start)
    else $error("cycle without latch");
  a_busy_holds: assert property ($rose(o_write_in_progress) |-> o_write_in_progress[*8])
    else $error("busy too short");
  a_erase_opens: assert property (o_erase_start |-> $rose(o_write_in_progress))
    else $error("erase outside cycle start");
  a_erase_pulse: assert property (o_erase_start |=> !o_erase_start)
    else $error("erase strobe held");
  a_pgm_in_cycle: assert property (o_pgm_we |-> o_write_in_progress)
    else $error("write outside cycle");
  a_sector_base: assert property (o_erase_start && o_erase_kind == sfpe_pkg::SFPE_ERASE_SECTOR
    |-> o_erase_addr[11:0] == 12'h000) else $error("sector base wrong");
  a_chip_base: assert property (o_erase_start && o_erase_kind == sfpe_pkg::SFPE_ERASE_CHIP
    |-> o_erase_addr == 32'h0) else $error("chip base wrong");
  a_sleep_idle: assert property (o_deep_sleep |-> !o_write_in_progress)
    else $error("asleep while busy");
endmodule
bind sfpe_sequencer sfpe_sequencer_monitor i_mon (.i_ref_clk, .i_reset, .o_write_enable_latch,
  .o_write_in_progress, .o_deep_sleep, .o_pgm_we, .o_erase_start, .o_erase_addr, .o_erase_kind);
`default_nettype wire

// ==== sfpe_host.sv ====
// host controller model driving the flash link
`timescale 1ns/1ps
`default_nettype none
module sfpe_host (
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic [3:0] o_q
);
  initial #1 {o_sclk, o_cs_n, o_q} = 6'h10;
  // lines set while sclk low, taken on its rise
  task automatic bit_out(input logic [3:0] v);
    o_q = v;
    #16 o_sclk = 1'b1;
    #16 o_sclk = 1'b0;
  endtask
  // one frame; sclk stands still outside it
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab, nib);
    logic [7:0] b;
    o_cs_n = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) bit_out({3'h0, op[i]});
    for (int i = ab - 1; i >= 0; i--) bit_out({3'h0, a[i]});
    for (int i = 0; i < nib; i++) begin
      b = 8'(i / 2 + i / 512) ^ 8'hA5;
      bit_out(i[0] ? b[3:0] : b[7:4]);
    end
    #40 o_cs_n = 1'b1;
    o_q = ~o_q;
  endtask
endmodule
`default_nettype wire

// ==== sfpe_sequencer_tb.sv ====
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module sfpe_sequencer_tb;
  logic clk = 1'b0, rst = 1'b1, sc, cs, sel = 1'b0, write_enable_latch, write_in_progress, address_size_flag, slp, pwe, es;
  logic [3:0] q, pl = 4'h0;
  logic [31:0] pa, ea, la, lea;
  logic [7:0] pd, ld;
  logic [1:0] ek, lek;
  logic [7:0] op [8] = '{8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'h60, 8'hC7};
  logic [55:0] rt [6] = '{56'h20_00A34567_17_00, 56'h60_00000000_01_00, 56'h32_00000310_18_05,
    56'h21_03FF1234_20_00, 56'h60_00000000_00_00, 56'h34_03FF0000_20_02};
  int bad_count = 0, total_checks = 0, np = 0, ne = 0;
  initial forever #4 clk = ~clk;
  sfpe_host h (.o_sclk(sc), .o_cs_n(cs), .o_q(q));
  sfpe_sequencer #(.PROGRAM_CYCLE_TIME_NS(4000), .SECTOR_ERASE_TIME_NS(800),
    .BLOCK_ERASE_TIME_NS(400), .ARRAY_ERASE_TIME_NS(400), .SLEEP_ENTRY_DELAY_NS(400)) i_dut (
    .i_ref_clk(clk), .i_reset(rst), .i_sclk(sc), .i_cs_n(cs), .i_quad_line_0(q[0]),
    .i_quad_line_1(q[1]), .i_quad_line_2(q[2]), .i_quad_line_3(q[3]),
    .i_protect_level_bit3(pl[3]), .i_protect_level_bit2(pl[2]), .i_protect_level_bit1(pl[1]),
    .i_protect_level_bit0(pl[0]), .i_protect_top_bottom_select(sel),
    .o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress), .o_address_size_flag(address_size_flag),
    .o_deep_sleep(slp), .o_pgm_we(pwe), .o_pgm_addr(pa), .o_pgm_data(pd),
    .o_erase_start(es), .o_erase_addr(ea), .o_erase_kind(ek));
  // record the write and erase strobes
  always @(posedge clk) begin
    np += int'(pwe);
    ne += int'(es);
    if (pwe) {la, ld} = {pa, pd};
    if (es) {lea, lek} = {ea, ek};
  end
  task automatic chk(input logic [71:0] g, e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] o, input logic [31:0] a, input int ab, nb);
    h.frame(o, a, ab, nb);
    repeat (5) @(posedge clk);
  endtask
  task automatic idle;
    for (int n = 0; write_in_progress === 1'b1; n++) begin
      @(posedge clk);
      if (n > 2000) report_and_stop(1);
    end
  endtask
  task automatic report_and_stop(input int extra);
    bad_count += extra;
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    chk({write_enable_latch, write_in_progress, address_size_flag, slp}, 0);
    cmd(8'h20, 0, 24, 0);
    chk(write_in_progress, 0);
    for (int i = 0; i < 8; i++) begin
      cmd(8'h06, 0, 0, 0);
      cmd(op[i], 32'hA34567, i < 6 ? 24 + 8 * i[0] : 0, 0);
      chk({ne, write_enable_latch, write_in_progress, lek, lea}, {i + 1, 2'b01, 2'(i / 2), i > 5 ? 32'h0 : 32'hA34567 &
        ~(i < 2 ? 32'hFFF : i < 4 ? 32'h7FFF : 32'hFFFF)});
      idle;
    end
    cmd(8'h06, 0, 0, 0);
    for (int i = 0; i < 6; i++) begin
      #1 pl = 4'(i > 2);
      cmd(rt[i][55:48], rt[i][47:16], rt[i][15:8], rt[i][7:0]);
      chk({write_enable_latch, write_in_progress}, 2'b10);
    end
    #1 pl = 4'h0;
    cmd(8'h32, 32'h310, 24, 6);
    chk({write_enable_latch, write_in_progress}, 2'b01);
    idle;
    chk({np, la, ld}, {32'd3, 32'h312, 8'hA7});
    cmd(8'h06, 0, 0, 0);
    cmd(8'h34, 32'h500F0, 32, 544);
    idle;
    chk({np, la, ld}, {32'd259, 32'h500FF, 8'hB5});
    cmd(8'h06, 0, 0, 0);
    cmd(8'h20, 0, 24, 0);
    cmd(8'hB9, 0, 0, 0);
    idle;
    repeat (80) @(posedge clk);
    chk(slp, 0);
    cmd(8'hB9, 0, 0, 0);
    chk(slp, 0);
    repeat (60) @(posedge clk);
    cmd(8'h06, 0, 0, 0);
    chk({slp, write_enable_latch}, 2'b10);
    cmd(8'hAB, 0, 0, 0);
    chk(slp, 0);
    cmd(8'hB7, 0, 0, 0);
    chk(address_size_flag, 1);
    report_and_stop(0);
  end
endmodule
`default_nettype wire
